// ---- afa_pkg.sv ----
// constants, register map and helpers for the converter flag aggregator
package afa_pkg;
    localparam int          CH_N          = 12;
    localparam int          CHW           = 4;
    localparam int          SEQ_N         = 2;
    localparam int          BYTE_W        = 8;
    localparam int          STRB_W        = 4;
    localparam int          AW            = 32;
    localparam int          DW            = 32;
    localparam logic [31:0] FLAGS_ADDR    = 32'h4001C068;
    localparam logic [31:0] IRQ_EN_ADDR   = 32'h4001C070;
    localparam logic [31:0] CROSS_EN_ADDR = 32'h4001C074;
    localparam logic [31:0] FLAGS_RST     = 32'h00000000;
    localparam logic [31:0] IRQ_EN_RST    = 32'h00000000;
    localparam logic [11:0] CROSS_EN_RST  = 12'h000;
    localparam logic [31:0] IRQ_EN_MASK   = 32'hF0000FFF;
    localparam logic [31:0] IRQ_SRC_MASK  = 32'hF0000000;
    localparam logic [1:0]  RESV_VAL      = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int          THR_LO        = 0;
    localparam int          OVR_LO        = 12;
    localparam int          MIR_LO        = 20;
    localparam int          SEQ_A_OVERRUN_MIRROR_BIT  = 24;
    localparam int          SEQ_B_OVERRUN_MIRROR_BIT  = 25;
    localparam int          SEQ_A_IRQ_FLAG_BIT  = 28;
    localparam int          SEQ_B_IRQ_FLAG_BIT  = 29;
    localparam int          THR_INT_BIT   = 30;
    localparam int          OVERRUN_SUMMARY_FLAG_BIT   = 31;

    // one-hot channel select, empty when not enabled or out of range
    function automatic logic [CH_N-1:0] chan_dec(input logic [CHW-1:0] ch,
                                                 input logic en);
        logic [CH_N-1:0] v;
        v = '0;
        for (int i = 0; i < CH_N; i++)
        begin
            if (en && (ch == CHW'(i)))
                v[i] = 1'b1;
        end
        return v;
    endfunction : chan_dec

    // byte strobes widened to a bit mask
    function automatic logic [DW-1:0] strb_mask(input logic [STRB_W-1:0] s);
        logic [DW-1:0] m;
        m = '0;
        for (int i = 0; i < STRB_W; i++)
            m[i*BYTE_W +: BYTE_W] = {BYTE_W{s[i]}};
        return m;
    endfunction : strb_mask

    // merge write data into an old value under the strobes
    function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] old,
                                             input logic [DW-1:0] data,
                                             input logic [STRB_W-1:0] s);
        logic [DW-1:0] m;
        m = strb_mask(s);
        return (old & ~m) | (data & m);
    endfunction : wmerge
endpackage : afa_pkg

// ---- afa_evt_if.sv ----
// set, clear and state bundle between a flag bank and its user
`timescale 1ns/1ns
interface afa_evt_if
#(
    parameter int W = 12
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] state;
    modport owner (input set, input clr, output state);
    modport user  (output set, output clr, input state);
endinterface : afa_evt_if

// ---- afa_sticky.sv ----
// bank of sticky flags, set wins over clear
`timescale 1ns/1ns
module afa_sticky
#(
    parameter int W = 12
)
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // flag bundle
    afa_evt_if.owner  ev
);
    import afa_pkg::*;
    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    assign flag_d   = (flag_q & ~ev.clr) | ev.set;
    assign ev.state = flag_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_q <= '0;
        else
            flag_q <= flag_d;
    end
endmodule : afa_sticky

// ---- afa_ovr_track.sv ----
// per-channel overrun bits, cleared by own or global result reads
`timescale 1ns/1ns
module afa_ovr_track
(
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // overrun bundle: set by events, clr by own result reads
    afa_evt_if.owner             ev,
    // global result reads with the channel they carried
    input  wire logic            glob_a_rd,
    input  wire logic [afa_pkg::CHW-1:0] glob_a_chan,
    input  wire logic            glob_b_rd,
    input  wire logic [afa_pkg::CHW-1:0] glob_b_chan
);
    import afa_pkg::*;
    logic [CH_N-1:0] ovr_q;
    logic [CH_N-1:0] rd_clr;

    assign rd_clr   = ev.clr | chan_dec(glob_a_chan, glob_a_rd)
                    | chan_dec(glob_b_chan, glob_b_rd);
    assign ev.state = ovr_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ovr_q <= '0;
        else
            ovr_q <= (ovr_q & ~rd_clr) | ev.set;
    end
endmodule : afa_ovr_track

// ---- afa_top.sv ----
// converter flag aggregator with its AXI4-Lite register slave
// Functional notes
// - bits 20..23 mirror overrun of channels 8..11, read only
// - bits 24 and 25 mirror global overrun of sequences A and B
// - mode 0, bit 28 follows sequence A result valid bit
// - mode 1, bit 28 set at end of A sequence, write one clears
// - mode 0, bit 29 follows sequence B result valid bit
// - mode 1, bit 29 set at end of B sequence, write one clears
// - sequence and overrun flags interrupt only when enabled
// - bit 30 set while any of twelve threshold flags is set
// - bit 30 clears only once all threshold flags are cleared
// - each threshold type per channel contributes only when enabled
// - bit 31 set while any channel overrun bit is set
// - global overrun feeds bit 31 only while that sequence mode is 0
// - bit 31 clears once every contributing overrun bit is cleared
// - threshold flag set on enabled event, cleared by writing one
// - channel overrun clears on own or global result read of it
`timescale 1ns/1ns
module afa_top
(
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // axi4-lite write address
    input  wire logic [afa_pkg::AW-1:0]  awaddr,
    input  wire logic [2:0]              awprot,
    input  wire logic                    awvalid,
    output logic                         awready,
    // axi4-lite write data
    input  wire logic [afa_pkg::DW-1:0]  wdata,
    input  wire logic [afa_pkg::STRB_W-1:0] wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    // axi4-lite write response
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // axi4-lite read address
    input  wire logic [afa_pkg::AW-1:0]  araddr,
    input  wire logic [2:0]              arprot,
    input  wire logic                    arvalid,
    output logic                         arready,
    // axi4-lite read data
    output logic [afa_pkg::DW-1:0]       rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // sequence status
    input  wire logic                    seq_a_mode,
    input  wire logic                    seq_b_mode,
    input  wire logic                    seq_a_valid,
    input  wire logic                    seq_b_valid,
    input  wire logic                    seq_a_done,
    input  wire logic                    seq_b_done,
    input  wire logic                    seq_a_glob_ovr,
    input  wire logic                    seq_b_glob_ovr,
    // channel overrun events and result reads
    input  wire logic [afa_pkg::CH_N-1:0] chan_ovr_set,
    input  wire logic [afa_pkg::CH_N-1:0] chan_rd,
    input  wire logic                    glob_a_rd,
    input  wire logic [afa_pkg::CHW-1:0] glob_a_chan,
    input  wire logic                    glob_b_rd,
    input  wire logic [afa_pkg::CHW-1:0] glob_b_chan,
    // threshold comparison events
    input  wire logic [afa_pkg::CH_N-1:0] thr_outside,
    input  wire logic [afa_pkg::CH_N-1:0] thr_cross,
    // results
    output logic [afa_pkg::CH_N-1:0]     chan_overrun,
    output logic                         adc_irq
);
    import afa_pkg::*;

    afa_evt_if #(.W(CH_N))  thr_if ();
    afa_evt_if #(.W(CH_N))  ovr_if ();
    afa_evt_if #(.W(SEQ_N)) seq_if ();

    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [DW-1:0]     rdata_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic [AW-1:0]     aw_addr_q;
    logic [DW-1:0]     w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic [DW-1:0]     en_q;
    logic [CH_N-1:0]   cross_q;
    logic              irq_q;

    logic              aw_fire;
    logic              w_fire;
    logic              ar_fire;
    logic              wr_do;
    logic              aw_have_d;
    logic              w_have_d;
    logic              wr_flags;
    logic              wr_en;
    logic              wr_cross;
    logic              wr_ok;
    logic              rd_ok;
    logic [DW-1:0]     w1c;
    logic [DW-1:0]     en_d;
    logic [DW-1:0]     cross_m;
    logic [DW-1:0]     rd_w;
    logic [DW-1:0]     flags_w;
    logic [CH_N-1:0]   thr_hit;
    logic              thr_sum;
    logic              ovr_sum;
    logic              seq_a_flag;
    logic              seq_b_flag;
    logic              irq_d;

    // bus handshakes
    assign aw_fire   = awvalid & awready_q;
    assign w_fire    = wvalid & wready_q;
    assign ar_fire   = arvalid & arready_q;
    assign wr_do     = aw_have_q & w_have_q & ~bvalid_q;
    assign aw_have_d = aw_have_q ? ~wr_do : aw_fire;
    assign w_have_d  = w_have_q ? ~wr_do : w_fire;

    // write decode
    assign wr_flags = wr_do & (aw_addr_q == FLAGS_ADDR);
    assign wr_en    = wr_do & (aw_addr_q == IRQ_EN_ADDR);
    assign wr_cross = wr_do & (aw_addr_q == CROSS_EN_ADDR);
    assign wr_ok    = (aw_addr_q == FLAGS_ADDR)
                    | (aw_addr_q == IRQ_EN_ADDR)
                    | (aw_addr_q == CROSS_EN_ADDR);
    assign w1c      = wr_flags ? (w_data_q & strb_mask(w_strb_q)) : '0;
    assign en_d     = wmerge(en_q, w_data_q, w_strb_q) & IRQ_EN_MASK;
    assign cross_m  = wmerge(DW'(cross_q), w_data_q, w_strb_q);

    // threshold flags
    assign thr_hit    = (thr_outside & en_q[CH_N-1:0])
                      | (thr_cross & cross_q);
    assign thr_if.set = thr_hit;
    assign thr_if.clr = w1c[THR_LO +: CH_N];
    assign thr_sum    = |thr_if.state;

    // channel overrun bits
    assign ovr_if.set = chan_ovr_set;
    assign ovr_if.clr = chan_rd;
    assign ovr_sum    = (|ovr_if.state)
                      | (seq_a_glob_ovr & ~seq_a_mode)
                      | (seq_b_glob_ovr & ~seq_b_mode);

    // sequence flags: sticky only in sequence-complete mode
    assign seq_if.set = {seq_b_done & seq_b_mode,
                         seq_a_done & seq_a_mode};
    assign seq_if.clr = {w1c[SEQ_B_IRQ_FLAG_BIT] | ~seq_b_mode,
                         w1c[SEQ_A_IRQ_FLAG_BIT] | ~seq_a_mode};
    assign seq_a_flag = seq_a_mode ? seq_if.state[0] : seq_a_valid;
    assign seq_b_flag = seq_b_mode ? seq_if.state[1] : seq_b_valid;

    // flag word; mirrors and summaries have no write path
    assign flags_w = {ovr_sum, thr_sum, seq_b_flag, seq_a_flag, RESV_VAL,
                      seq_b_glob_ovr, seq_a_glob_ovr,
                      ovr_if.state, thr_if.state};

    // interrupt request
    assign irq_d = |(flags_w & en_q & IRQ_SRC_MASK);

    // read decode
    assign rd_ok = (araddr == FLAGS_ADDR)
                 | (araddr == IRQ_EN_ADDR)
                 | (araddr == CROSS_EN_ADDR);
    assign rd_w  = (araddr == FLAGS_ADDR)    ? flags_w :
                   (araddr == IRQ_EN_ADDR)   ? en_q :
                   (araddr == CROSS_EN_ADDR) ? DW'(cross_q) : '0;

    afa_sticky #(.W(CH_N)) u_thr
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ev      (thr_if.owner)
    );

    afa_sticky #(.W(SEQ_N)) u_seq
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ev      (seq_if.owner)
    );

    afa_ovr_track u_ovr
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ev          (ovr_if.owner),
        .glob_a_rd   (glob_a_rd),
        .glob_a_chan (glob_a_chan),
        .glob_b_rd   (glob_b_rd),
        .glob_b_chan (glob_b_chan)
    );

    // write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awready_q <= ~aw_have_d;
            wready_q  <= ~w_have_d;
            if (wr_do)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_q <= 1'b0;
        end
    end

    // write payload capture
    always_ff @(posedge aclk)
    begin
        if (aw_fire)
            aw_addr_q <= awaddr;
        if (w_fire)
        begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end
        else if (ar_fire)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q   <= rd_w;
        end
        else if (rvalid_q && rready)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
        else if (!rvalid_q)
            arready_q <= 1'b1;
    end

    // enable registers and interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_q    <= IRQ_EN_RST;
            cross_q <= CROSS_EN_RST;
            irq_q   <= 1'b0;
        end
        else
        begin
            if (wr_en)
                en_q <= en_d;
            if (wr_cross)
                cross_q <= cross_m[CH_N-1:0];
            irq_q <= irq_d;
        end
    end

    assign awready      = awready_q;
    assign wready       = wready_q;
    assign bvalid       = bvalid_q;
    assign bresp        = bresp_q;
    assign arready      = arready_q;
    assign rvalid       = rvalid_q;
    assign rresp        = rresp_q;
    assign rdata        = rdata_q;
    assign chan_overrun = ovr_if.state;
    assign adc_irq      = irq_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_chan_mirror;
        chan_ovr_set[CH_N-1] |=> flags_w[MIR_LO+3] && chan_overrun[CH_N-1];
    endproperty
    a_chan_mirror: assert property (p_chan_mirror)
        else $error("channel 11 overrun not mirrored");

    property p_glob_mirror;
        seq_b_glob_ovr |-> flags_w[SEQ_B_OVERRUN_MIRROR_BIT] && flags_w[SEQ_B_OVERRUN_MIRROR_BIT-1]
                           == seq_a_glob_ovr;
    endproperty
    a_glob_mirror: assert property (p_glob_mirror)
        else $error("global overrun mirror wrong");

    property p_seq_a_track;
        !seq_a_mode |-> flags_w[SEQ_A_IRQ_FLAG_BIT] == seq_a_valid;
    endproperty
    a_seq_a_track: assert property (p_seq_a_track)
        else $error("sequence A flag not following valid bit");

    property p_seq_a_done;
        seq_a_mode && seq_a_done |=> !seq_a_mode || flags_w[SEQ_A_IRQ_FLAG_BIT];
    endproperty
    a_seq_a_done: assert property (p_seq_a_done)
        else $error("sequence A completion not flagged");

    property p_seq_b_track;
        !seq_b_mode |-> flags_w[SEQ_B_IRQ_FLAG_BIT] == seq_b_valid;
    endproperty
    a_seq_b_track: assert property (p_seq_b_track)
        else $error("sequence B flag not following valid bit");

    property p_seq_b_w1c;
        seq_b_mode && wr_flags && w1c[SEQ_B_IRQ_FLAG_BIT] && !seq_b_done
        |=> !flags_w[SEQ_B_IRQ_FLAG_BIT] || !seq_b_mode || seq_b_done;
    endproperty
    a_seq_b_w1c: assert property (p_seq_b_w1c)
        else $error("sequence B flag not cleared by write");

    property p_irq_on;
        |(flags_w & en_q & IRQ_SRC_MASK) |=> adc_irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled flag raised no interrupt");

    property p_irq_off;
        (en_q & IRQ_SRC_MASK) == '0 |=> !adc_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised with enables clear");

    property p_thr_set;
        |thr_hit |=> flags_w[THR_INT_BIT];
    endproperty
    a_thr_set: assert property (p_thr_set)
        else $error("threshold event not summarised");

    property p_thr_fall;
        $fell(flags_w[THR_INT_BIT]) |-> $past(wr_flags);
    endproperty
    a_thr_fall: assert property (p_thr_fall)
        else $error("threshold summary cleared without a write");

    property p_thr_gate;
        (thr_hit == '0) && !thr_sum |=> !flags_w[THR_INT_BIT];
    endproperty
    a_thr_gate: assert property (p_thr_gate)
        else $error("threshold summary set without enabled event");

    property p_ovr_sum;
        |chan_ovr_set |=> flags_w[OVERRUN_SUMMARY_FLAG_BIT];
    endproperty
    a_ovr_sum: assert property (p_ovr_sum)
        else $error("channel overrun not summarised");

    property p_glob_ovr_mode;
        (ovr_if.state == '0) && (seq_a_mode || !seq_a_glob_ovr)
        && (seq_b_mode || !seq_b_glob_ovr)
        |-> !flags_w[OVERRUN_SUMMARY_FLAG_BIT];
    endproperty
    a_glob_ovr_mode: assert property (p_glob_ovr_mode)
        else $error("global overrun counted in sequence mode");

    property p_glob_rd_clr;
        glob_a_rd && (glob_a_chan == CHW'(0)) && !chan_ovr_set[0]
        |=> !chan_overrun[0];
    endproperty
    a_glob_rd_clr: assert property (p_glob_rd_clr)
        else $error("global read left channel overrun set");

    property p_bresp;
        wr_do |=> bvalid && (bresp == ($past(wr_ok) ? RESP_OKAY
                                                    : RESP_SLVERR));
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response missing or wrong");
endmodule : afa_top

// ---- tb_afa_top.sv ----
// self-checking bench for the converter flag aggregator
`timescale 1ns/1ns
module tb_afa_top;
    import afa_pkg::*;
    logic              aclk, aresetn;
    logic [AW-1:0]     awaddr, araddr;
    logic [DW-1:0]     wdata, rdata, rd;
    logic [STRB_W-1:0] wstrb;
    logic [2:0]        awprot, arprot;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp, resp;
    logic              seq_a_mode, seq_b_mode, seq_a_valid, seq_b_valid;
    logic              seq_a_done, seq_b_done, seq_a_glob_ovr, seq_b_glob_ovr;
    logic [CH_N-1:0]   chan_ovr_set, chan_rd, thr_outside, thr_cross;
    logic [CH_N-1:0]   chan_overrun;
    logic              glob_a_rd, glob_b_rd, adc_irq;
    logic [CHW-1:0]    glob_a_chan, glob_b_chan;
    int                n_fail, total_checks;

    afa_top afa_top_inst
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .seq_a_mode(seq_a_mode),
        .seq_b_mode(seq_b_mode), .seq_a_valid(seq_a_valid),
        .seq_b_valid(seq_b_valid), .seq_a_done(seq_a_done),
        .seq_b_done(seq_b_done), .seq_a_glob_ovr(seq_a_glob_ovr),
        .seq_b_glob_ovr(seq_b_glob_ovr), .chan_ovr_set(chan_ovr_set),
        .chan_rd(chan_rd), .glob_a_rd(glob_a_rd), .glob_a_chan(glob_a_chan),
        .glob_b_rd(glob_b_rd), .glob_b_chan(glob_b_chan),
        .thr_outside(thr_outside), .thr_cross(thr_cross),
        .chan_overrun(chan_overrun), .adc_irq(adc_irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic give_verdict;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask : check

    task automatic edges(input int k);
        repeat (k) @(posedge aclk);
    endtask : edges

    // write one word, full strobes, wait for the response
    task automatic axi_write(input logic [31:0] a, d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (n == 50)
        begin
            n_fail++;
            give_verdict();
        end
        @(posedge aclk);
    endtask : axi_write

    // read one word into rd and resp
    task automatic axi_read(input logic [31:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n == 50)
        begin
            n_fail++;
            give_verdict();
        end
        @(posedge aclk);
    endtask : axi_read

    task automatic chk_reg(input logic [31:0] a, exp, input string what);
        axi_read(a);
        check(rd, exp, what);
    endtask : chk_reg

    task automatic reset_and_map;
        chk_reg(FLAGS_ADDR, FLAGS_RST, "flags reset");
        chk_reg(IRQ_EN_ADDR, IRQ_EN_RST, "enable reset");
        chk_reg(CROSS_EN_ADDR, 32'(CROSS_EN_RST), "cross enable reset");
        chk_reg(32'h4001C06C, 32'h00000000, "unmapped read data");
        check(32'(resp), 32'(RESP_SLVERR), "unmapped read resp");
        axi_write(32'h4001C078, 32'hFFFFFFFF);
        check(32'(resp), 32'(RESP_SLVERR), "unmapped write resp");
    endtask : reset_and_map

    task automatic overrun_paths;
        chan_ovr_set <= 12'hF00;
        edges(1);
        chan_ovr_set <= 12'h000;
        chk_reg(FLAGS_ADDR, 32'h80F00000, "overrun mirrors");
        check(32'(chan_overrun), 32'h00000F00, "overrun out");
        axi_write(FLAGS_ADDR, 32'hC3F00000);
        chk_reg(FLAGS_ADDR, 32'h80F00000, "read only bits");
        chan_rd <= 12'h100;
        glob_a_rd <= 1'b1;
        glob_a_chan <= 4'h9;
        glob_b_rd <= 1'b1;
        glob_b_chan <= 4'hA;
        edges(1);
        chan_rd <= 12'h000;
        glob_a_chan <= 4'hC;
        glob_b_rd <= 1'b0;
        edges(1);
        glob_a_rd <= 1'b0;
        chk_reg(FLAGS_ADDR, 32'h80800000, "own and global reads");
        chan_rd <= 12'h800;
        edges(1);
        chan_rd <= 12'h000;
        chk_reg(FLAGS_ADDR, 32'h00000000, "overrun summary clear");
    endtask : overrun_paths

    task automatic global_mirrors;
        seq_a_glob_ovr <= 1'b1;
        chk_reg(FLAGS_ADDR, 32'h81000000, "seq a overrun mode 0");
        seq_a_mode <= 1'b1;
        chk_reg(FLAGS_ADDR, 32'h01000000, "seq a overrun mode 1");
        seq_a_glob_ovr <= 1'b0;
        seq_a_mode <= 1'b0;
        seq_b_glob_ovr <= 1'b1;
        chk_reg(FLAGS_ADDR, 32'h82000000, "seq b overrun mode 0");
        seq_b_glob_ovr <= 1'b0;
    endtask : global_mirrors

    task automatic sequence_flags;
        seq_a_valid <= 1'b1;
        seq_b_valid <= 1'b1;
        chk_reg(FLAGS_ADDR, 32'h30000000, "valid mirror");
        seq_a_valid <= 1'b0;
        seq_b_valid <= 1'b0;
        chk_reg(FLAGS_ADDR, 32'h00000000, "valid cleared");
        seq_a_mode <= 1'b1;
        seq_b_mode <= 1'b1;
        seq_a_valid <= 1'b1;
        chk_reg(FLAGS_ADDR, 32'h00000000, "valid ignored mode 1");
        seq_a_valid <= 1'b0;
        seq_a_done <= 1'b1;
        seq_b_done <= 1'b1;
        edges(1);
        seq_a_done <= 1'b0;
        seq_b_done <= 1'b0;
        chk_reg(FLAGS_ADDR, 32'h30000000, "sequence done");
        axi_write(FLAGS_ADDR, 32'h10000000);
        chk_reg(FLAGS_ADDR, 32'h20000000, "clear seq a");
        axi_write(FLAGS_ADDR, 32'h20000000);
        chk_reg(FLAGS_ADDR, 32'h00000000, "clear seq b");
        seq_a_mode <= 1'b0;
        seq_b_mode <= 1'b0;
    endtask : sequence_flags

    task automatic threshold_flags;
        thr_outside <= 12'hFFF;
        thr_cross <= 12'hFFF;
        edges(1);
        chk_reg(FLAGS_ADDR, 32'h00000000, "threshold disabled");
        axi_write(IRQ_EN_ADDR, 32'h00000001);
        axi_write(CROSS_EN_ADDR, 32'h00000002);
        chk_reg(CROSS_EN_ADDR, 32'h00000002, "cross enable");
        thr_outside <= 12'h003;
        thr_cross <= 12'h003;
        edges(1);
        thr_outside <= 12'h000;
        thr_cross <= 12'h000;
        chk_reg(FLAGS_ADDR, 32'h40000003, "threshold set");
        axi_write(FLAGS_ADDR, 32'h00000001);
        chk_reg(FLAGS_ADDR, 32'h40000002, "summary held");
        axi_write(FLAGS_ADDR, 32'h00000002);
        chk_reg(FLAGS_ADDR, 32'h00000000, "summary clear");
    endtask : threshold_flags

    task automatic irq_gating;
        axi_write(IRQ_EN_ADDR, 32'hFFFFFFFF);
        chk_reg(IRQ_EN_ADDR, IRQ_EN_MASK, "enable mask");
        check(32'(adc_irq), 32'h0, "irq idle");
        chan_ovr_set <= 12'h001;
        edges(1);
        chan_ovr_set <= 12'h000;
        edges(2);
        check(32'(adc_irq), 32'h1, "irq on overrun");
        axi_write(IRQ_EN_ADDR, 32'h70000000);
        edges(2);
        check(32'(adc_irq), 32'h0, "irq masked");
        axi_write(IRQ_EN_ADDR, 32'h80000000);
        edges(2);
        check(32'(adc_irq), 32'h1, "irq unmasked");
        glob_a_chan <= 4'h0;
        glob_a_rd <= 1'b1;
        edges(1);
        glob_a_rd <= 1'b0;
        edges(2);
        check(32'(adc_irq), 32'h0, "irq after read");
        axi_write(IRQ_EN_ADDR, 32'h00000000);
    endtask : irq_gating

    initial
    begin
        n_fail = 0;
        total_checks = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, awprot, arprot} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        {seq_a_mode, seq_b_mode, seq_a_valid, seq_b_valid} = '0;
        {seq_a_done, seq_b_done, seq_a_glob_ovr, seq_b_glob_ovr} = '0;
        {chan_ovr_set, chan_rd, thr_outside, thr_cross} = '0;
        {glob_a_rd, glob_b_rd, glob_a_chan, glob_b_chan} = '0;
        edges(2);
        aresetn <= 1'b1;
        edges(2);
        reset_and_map();
        overrun_paths();
        global_mirrors();
        sequence_flags();
        threshold_flags();
        irq_gating();
        give_verdict();
    end
endmodule : tb_afa_top
